// >>> irdr_top.sv
// IRQ and DMA routing for the floppy, parallel and two serial logical devices.
// Assumes a byte-wide configuration index/data port and synchronous unit status.
`timescale 1ns/1ps
`include "irdr_params.svh"

module irdr_top
  import irdr_pkg::*;
(
  // Clock and resets
  input wire logic mclk,
  input wire logic resetn,
  input wire logic host_bus_reset_n,
  // Configuration index/data port
  input wire logic cfg_sel,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Floppy unit status
  input wire logic floppy_dma_irq_gate,
  input wire logic fdc_powered_down,
  // Parallel port unit status
  input wire logic pp_ecp_mode,
  input wire logic [2:0] pp_ecr_mode,
  input wire logic port_irq_enable,
  input wire logic service_irq_mask,
  input wire logic ecp_dma_enable,
  // Serial unit status
  input wire logic [3:0] uart1_irq_enable_reg,
  input wire logic [3:0] uart2_irq_enable_reg,
  input wire logic uart1_modem_aux_output_two,
  input wire logic uart2_modem_aux_output_two,
  // Raw requests from the units
  input wire logic fdc_irq_req,
  input wire logic fdc_dma_req,
  input wire logic pp_irq_req,
  input wire logic port_dma_request,
  input wire logic uart1_irq_req,
  input wire logic uart2_irq_req,
  input wire logic smi_req,
  // Routed lines to the host controllers
  output logic [15:1] irq_line,
  output logic [3:1] dma_line,
  output logic system_mgmt_irq_n,
  // Floppy drive interface
  input wire logic write_protect_in_n,
  input wire logic drive_select0_n,
  input wire logic drive_select1_n,
  input wire logic density_in,
  output logic fdc_write_protect_n,
  output logic density_out,
  // Floppy mode controls
  output logic fdc_enhanced_mode2,
  output logic fdc_nonburst_dma,
  output logic [1:0] fdc_if_mode
);
  import irdr_pkg::*;

  irdr_top_state_t q;
  irdr_top_state_t d;

  irdr_route_if rif ();

  // Slot defaults; devices 3 and 5 share the no-DMA value, serial 1 too
  function automatic irdr_slot_t slot_default(input int idx);
    irdr_slot_t v;
    v.active = 1'b0;
    v.base = `IRDR_BASE_RST;
    v.irq_sel = (idx == 0) ? `IRDR_IRQ_RST_FDC : `IRDR_IRQ_RST_OTHER;
    v.dma_sel = (idx == 0) ? `IRDR_DMA_RST_FDC : `IRDR_DMA_RST_OTHER;
    return v;
  endfunction

  function automatic irdr_top_state_t state_default();
    irdr_top_state_t v;
    v.index = 8'h00;
    v.ldn = `IRDR_LDN_FDC;
    for (int i = 0; i < `IRDR_SLOTS; i++) begin
      v.slot[i] = slot_default(i);
    end
    v.fdd_mode = `IRDR_FDD_MODE_RST;
    v.fdd_opt = `IRDR_FDD_OPT_RST;
    v.rdata = 8'h00;
    v.irq_out = '0;
    v.dma_out = '0;
    v.smi_n = 1'b1;
    v.wp_n = 1'b1;
    v.density = 1'b0;
    return v;
  endfunction

  // Reset image built once, so both reset paths load a plain constant
  localparam irdr_top_state_t state_rst = state_default();

  // Logical device number to slot; unknown devices hit nothing
  logic slot_hit;
  logic [1:0] slot_idx;
  logic is_fdc;

  always_comb begin
    slot_hit = 1'b1;
    slot_idx = 2'd0;
    unique case (q.ldn)
      `IRDR_LDN_FDC: slot_idx = 2'd0;
      `IRDR_LDN_PP: slot_idx = 2'd1;
      `IRDR_LDN_UART1: slot_idx = 2'd2;
      `IRDR_LDN_UART2: slot_idx = 2'd3;
      default: slot_hit = 1'b0;
    endcase
    is_fdc = (q.ldn == `IRDR_LDN_FDC);
  end

  // Config read mux; reserved bits and unmapped indices read zero
  logic [7:0] reg_rd;

  always_comb begin
    reg_rd = 8'h00;
    unique case (q.index)
      `IRDR_IDX_CFG_CTRL: reg_rd = 8'h00; // Soft reset bit self-clears
      `IRDR_IDX_LDN: reg_rd = q.ldn;
      `IRDR_IDX_ACTIVATE: begin
        if (slot_hit) begin
          reg_rd[`IRDR_ACT_BIT] = q.slot[slot_idx].active;
        end
      end
      `IRDR_IDX_BASE_HI: begin
        if (slot_hit) begin
          reg_rd = q.slot[slot_idx].base[15:8];
        end
      end
      `IRDR_IDX_BASE_LO: begin
        if (slot_hit) begin
          reg_rd = q.slot[slot_idx].base[7:0];
        end
      end
      `IRDR_IDX_IRQ_SEL: begin
        if (slot_hit) begin
          reg_rd[3:0] = q.slot[slot_idx].irq_sel;
        end
      end
      `IRDR_IDX_DMA_SEL: begin
        if (slot_hit) begin
          reg_rd[2:0] = q.slot[slot_idx].dma_sel;
        end
      end
      `IRDR_IDX_FDD_MODE: begin
        if (is_fdc) begin
          reg_rd = q.fdd_mode;
        end
      end
      `IRDR_IDX_FDD_OPT: begin
        if (is_fdc) begin
          reg_rd = q.fdd_opt;
        end
      end
      default: reg_rd = 8'h00;
    endcase
  end

  // Floppy pin conditioning
  logic drive_selected;
  logic [1:0] dens_field;
  logic wp_forced;
  logic wp_active;
  logic density_next;

  // Registered: one cycle from drive pin to floppy core
  always_comb begin
    drive_selected = !drive_select0_n || !drive_select1_n;
    wp_forced = q.fdd_opt[`IRDR_OPT_FWP_BIT] && drive_selected;
    wp_active = wp_forced || !write_protect_in_n;
    dens_field = q.fdd_opt[`IRDR_OPT_DENS_LO +: 2];
    unique case (dens_field)
      `IRDR_DENS_FORCE1: density_next = 1'b1;
      `IRDR_DENS_FORCE0: density_next = 1'b0;
      default: density_next = density_in;
    endcase
  end

  // Hand the live configuration and requests to the router
  always_comb begin
    rif.slot = q.slot;
    rif.irq_req = {uart2_irq_req, uart1_irq_req, pp_irq_req, fdc_irq_req};
    // Serial slots raise no DMA, so their channel selection stays inert
    rif.dma_req = {1'b0, 1'b0, port_dma_request, fdc_dma_req};
    rif.floppy_dma_irq_gate = floppy_dma_irq_gate;
    rif.fdc_powered_down = fdc_powered_down;
    rif.pp_ecp_mode = pp_ecp_mode;
    rif.pp_ecr_mode = pp_ecr_mode;
    rif.port_irq_enable = port_irq_enable;
    rif.service_irq_mask = service_irq_mask;
    rif.ecp_dma_enable = ecp_dma_enable;
    rif.uart1_irq_enable_reg = uart1_irq_enable_reg;
    rif.uart2_irq_enable_reg = uart2_irq_enable_reg;
    rif.uart1_modem_aux_output_two = uart1_modem_aux_output_two;
    rif.uart2_modem_aux_output_two = uart2_modem_aux_output_two;
  end

  irdr_gate u_gate (
    .g(rif.gate)
  );

  irdr_route u_route (
    .r(rif.route)
  );

  // Next state
  logic soft_reset;
  logic data_wr;
  logic hard_reset;

  always_comb begin
    d = q;
    soft_reset = 1'b0;
    data_wr = cfg_wr && cfg_sel;
    hard_reset = !host_bus_reset_n;

    if (cfg_wr && !cfg_sel) begin
      d.index = cfg_wdata;
    end

    if (data_wr) begin
      unique case (q.index)
        `IRDR_IDX_CFG_CTRL: soft_reset = cfg_wdata[`IRDR_CTRL_SOFT_BIT];
        `IRDR_IDX_LDN: d.ldn = cfg_wdata;
        `IRDR_IDX_ACTIVATE: begin
          if (slot_hit) begin
            d.slot[slot_idx].active = cfg_wdata[`IRDR_ACT_BIT];
          end
        end
        `IRDR_IDX_BASE_HI: begin
          if (slot_hit) begin
            d.slot[slot_idx].base[15:8] = cfg_wdata;
          end
        end
        `IRDR_IDX_BASE_LO: begin
          if (slot_hit) begin
            d.slot[slot_idx].base[7:0] = cfg_wdata;
          end
        end
        `IRDR_IDX_IRQ_SEL: begin
          // Level two is an ordinary routed level; the SMI line is driven apart from it
          if (slot_hit) begin
            d.slot[slot_idx].irq_sel = cfg_wdata[3:0];
          end
        end
        `IRDR_IDX_DMA_SEL: begin
          if (slot_hit) begin
            d.slot[slot_idx].dma_sel = cfg_wdata[2:0];
          end
        end
        `IRDR_IDX_FDD_MODE: begin
          if (is_fdc) begin
            d.fdd_mode = cfg_wdata;
          end
        end
        `IRDR_IDX_FDD_OPT: begin
          if (is_fdc) begin
            d.fdd_opt = cfg_wdata;
          end
        end
        default: ;
      endcase
    end

    // Soft reset spares the vendor floppy registers
    if (soft_reset) begin
      d.ldn = `IRDR_LDN_FDC;
      for (int i = 0; i < `IRDR_SLOTS; i++) begin
        d.slot[i] = slot_default(i);
      end
    end

    // Read data stands from the edge after cfg_rd until the next read
    // A same-cycle write is not seen: the mux reads the old registers
    if (cfg_rd) begin
      d.rdata = cfg_sel ? reg_rd : q.index;
    end

    d.irq_out = rif.irq_vec;
    d.dma_out = rif.dma_vec;
    d.smi_n = !smi_req;
    d.wp_n = !wp_active;
    d.density = density_next;

    // Hard reset loads the reset image into everything, vendor registers included
    if (hard_reset) begin
      d = state_rst;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= state_rst;
    end else begin
      q <= d;
    end
  end

  // Outputs
  // Routed lines are registered levels, one cycle behind their request
  assign cfg_rdata = q.rdata;
  assign irq_line = q.irq_out;
  assign dma_line = q.dma_out;
  assign system_mgmt_irq_n = q.smi_n;
  assign fdc_write_protect_n = q.wp_n;
  assign density_out = q.density;

  // Mode fields go out straight from the register, reserved codes included
  assign fdc_enhanced_mode2 = q.fdd_mode[`IRDR_MODE_ENH2_BIT];
  assign fdc_nonburst_dma = q.fdd_mode[`IRDR_MODE_NONBURST_BIT];
  assign fdc_if_mode = q.fdd_mode[`IRDR_MODE_IF_LO +: 2];
endmodule

// >>> irdr_params.svh
// Constants for the IRQ and DMA routing block: config indices, resets, fields.
// Assumes byte-wide configuration index/data access.
`ifndef IRDR_PARAMS_SVH
`define IRDR_PARAMS_SVH

`define IRDR_SLOTS 4
`define IRDR_IDX_CFG_CTRL 8'h02
`define IRDR_IDX_LDN 8'h07
`define IRDR_IDX_ACTIVATE 8'h30
`define IRDR_IDX_BASE_HI 8'h60
`define IRDR_IDX_BASE_LO 8'h61
`define IRDR_IDX_IRQ_SEL 8'h70
`define IRDR_IDX_DMA_SEL 8'h74
`define IRDR_IDX_FDD_MODE 8'hf0
`define IRDR_IDX_FDD_OPT 8'hf1

`define IRDR_LDN_FDC 8'h00
`define IRDR_LDN_PP 8'h03
`define IRDR_LDN_UART1 8'h04
`define IRDR_LDN_UART2 8'h05

`define IRDR_IRQ_NONE 4'h0
`define IRDR_IRQ_RST_FDC 4'h6
`define IRDR_IRQ_RST_OTHER 4'h0
`define IRDR_DMA_RST_FDC 3'h2
`define IRDR_DMA_RST_OTHER 3'h4
`define IRDR_DMA_FIRST 3'h1
`define IRDR_DMA_LAST 3'h3
`define IRDR_FDD_MODE_RST 8'h0e
`define IRDR_FDD_OPT_RST 8'h00
`define IRDR_BASE_RST 16'h0000
`define IRDR_BASE_MIN 16'h0100
`define IRDR_BASE_MAX 16'h0fff

`define IRDR_CTRL_SOFT_BIT 0
`define IRDR_ACT_BIT 0
`define IRDR_MODE_ENH2_BIT 0
`define IRDR_MODE_NONBURST_BIT 1
`define IRDR_MODE_IF_LO 2
`define IRDR_OPT_FWP_BIT 0
`define IRDR_OPT_DENS_LO 2

`define IRDR_DENS_FORCE1 2'b10
`define IRDR_DENS_FORCE0 2'b11
`define IRDR_ECR_FIFO 3'b010
`define IRDR_ECR_ECP 3'b011
`define IRDR_ECR_TEST 3'b110

`endif

// >>> irdr_pkg.sv
// Types for the IRQ and DMA routing block.
// Assumes irdr_params.svh is on the include path.
`include "irdr_params.svh"

package irdr_pkg;

  typedef struct packed {
    logic active;
    logic [15:0] base;
    logic [3:0] irq_sel;
    logic [2:0] dma_sel;
  } irdr_slot_t;

  typedef irdr_slot_t [`IRDR_SLOTS-1:0] irdr_slots_t;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] ldn;
    irdr_slots_t slot;
    logic [7:0] fdd_mode;
    logic [7:0] fdd_opt;
    logic [7:0] rdata;
    logic [15:1] irq_out;
    logic [3:1] dma_out;
    logic smi_n;
    logic wp_n;
    logic density;
  } irdr_top_state_t;

endpackage

// >>> irdr_route_if.sv
// Carrier between the routing top, its gate decoder and its line router.
// Assumes all three sit in the mclk domain.
`timescale 1ns/1ps
`include "irdr_params.svh"

interface irdr_route_if;
  import irdr_pkg::*;

  irdr_slots_t slot;
  logic [`IRDR_SLOTS-1:0] irq_req;
  logic [`IRDR_SLOTS-1:0] dma_req;
  logic [`IRDR_SLOTS-1:0] fen_irq;
  logic [`IRDR_SLOTS-1:0] fen_dma;
  logic floppy_dma_irq_gate;
  logic fdc_powered_down;
  logic pp_ecp_mode;
  logic [2:0] pp_ecr_mode;
  logic port_irq_enable;
  logic service_irq_mask;
  logic ecp_dma_enable;
  logic [3:0] uart1_irq_enable_reg;
  logic [3:0] uart2_irq_enable_reg;
  logic uart1_modem_aux_output_two;
  logic uart2_modem_aux_output_two;
  logic [15:1] irq_vec;
  logic [3:1] dma_vec;

  modport top (
    output slot, irq_req, dma_req,
    output floppy_dma_irq_gate, fdc_powered_down, pp_ecp_mode, pp_ecr_mode,
    output port_irq_enable, service_irq_mask, ecp_dma_enable,
    output uart1_irq_enable_reg, uart2_irq_enable_reg,
    output uart1_modem_aux_output_two, uart2_modem_aux_output_two,
    input irq_vec, dma_vec
  );

  modport gate (
    input floppy_dma_irq_gate, fdc_powered_down, pp_ecp_mode, pp_ecr_mode,
    input port_irq_enable, service_irq_mask, ecp_dma_enable,
    input uart1_irq_enable_reg, uart2_irq_enable_reg,
    input uart1_modem_aux_output_two, uart2_modem_aux_output_two,
    output fen_irq, fen_dma
  );

  modport route (
    input slot, irq_req, dma_req, fen_irq, fen_dma,
    output irq_vec, dma_vec
  );
endinterface

// >>> irdr_gate.sv
// Function-level interrupt and DMA enables per logical device slot.
// Slots: 0 floppy, 1 parallel port, 2 serial 1, 3 serial 2.
`timescale 1ns/1ps
`include "irdr_params.svh"

module irdr_gate (
  // Unit status in, enables out
  irdr_route_if.gate g
);
  import irdr_pkg::*;

  logic pp_irq_always_on;
  logic floppy_ok;

  always_comb begin
    floppy_ok = g.floppy_dma_irq_gate && !g.fdc_powered_down;
    pp_irq_always_on = (g.pp_ecr_mode == `IRDR_ECR_FIFO) ||
                       (g.pp_ecr_mode == `IRDR_ECR_ECP) ||
                       (g.pp_ecr_mode == `IRDR_ECR_TEST);
    g.fen_irq = '0;
    g.fen_dma = '0;
    g.fen_irq[0] = floppy_ok;
    g.fen_dma[0] = floppy_ok;
    if (g.pp_ecp_mode) begin
      // Mask bit wins even where the mode table says always on
      g.fen_irq[1] = (pp_irq_always_on || g.port_irq_enable) && !g.service_irq_mask;
      g.fen_dma[1] = g.ecp_dma_enable;
    end else begin
      g.fen_irq[1] = g.port_irq_enable;
      g.fen_dma[1] = 1'b0;
    end
    g.fen_irq[2] = (|g.uart1_irq_enable_reg) && g.uart1_modem_aux_output_two;
    g.fen_irq[3] = (|g.uart2_irq_enable_reg) && g.uart2_modem_aux_output_two;
  end
endmodule

// >>> irdr_route.sv
// Maps qualified device requests onto the fifteen IRQ levels and three DMA channels.
// All levels are routable so a serial IRQ encoder downstream sees every one.
`timescale 1ns/1ps
`include "irdr_params.svh"

module irdr_route (
  // Slot config, requests and enables in, lines out
  irdr_route_if.route r
);
  import irdr_pkg::*;

  logic [`IRDR_SLOTS-1:0] irq_ok;
  logic [`IRDR_SLOTS-1:0] dma_ok;
  logic [15:1][`IRDR_SLOTS-1:0] irq_hit;
  logic [3:1][`IRDR_SLOTS-1:0] dma_hit;

  genvar s, l;
  generate
    for (s = 0; s < `IRDR_SLOTS; s++) begin : g_slot
      logic base_ok;
      assign base_ok = (r.slot[s].base >= `IRDR_BASE_MIN) && (r.slot[s].base <= `IRDR_BASE_MAX);
      assign irq_ok[s] = r.slot[s].active && base_ok && r.fen_irq[s] && r.irq_req[s] &&
                         (r.slot[s].irq_sel != `IRDR_IRQ_NONE);
      assign dma_ok[s] = r.slot[s].active && base_ok && r.fen_dma[s] && r.dma_req[s] &&
                         (r.slot[s].dma_sel >= `IRDR_DMA_FIRST) &&
                         (r.slot[s].dma_sel <= `IRDR_DMA_LAST);
      for (l = 1; l <= 15; l++) begin : g_lvl
        assign irq_hit[l][s] = irq_ok[s] && (r.slot[s].irq_sel == 4'(l));
      end
      for (l = 1; l <= 3; l++) begin : g_ch
        assign dma_hit[l][s] = dma_ok[s] && (r.slot[s].dma_sel == 3'(l));
      end
    end
    for (l = 1; l <= 15; l++) begin : g_irq_or
      assign r.irq_vec[l] = |irq_hit[l];
    end
    for (l = 1; l <= 3; l++) begin : g_dma_or
      assign r.dma_vec[l] = |dma_hit[l];
    end
  endgenerate
endmodule

// >>> irdr_top_monitor.sv
// Port-level checker for the IRQ and DMA routing top.
// Assumes it is bound onto irdr_top; everything sits in the mclk domain.
`timescale 1ns/1ps

module irdr_top_monitor (
  // Clock and resets
  input wire logic mclk,
  input wire logic resetn,
  input wire logic host_bus_reset_n,
  // Config strobe
  input wire logic cfg_wr,
  // Unit status and raw requests
  input wire logic floppy_dma_irq_gate,
  input wire logic fdc_powered_down,
  input wire logic ecp_dma_enable,
  input wire logic [3:0] uart1_irq_enable_reg,
  input wire logic [3:0] uart2_irq_enable_reg,
  input wire logic uart1_modem_aux_output_two,
  input wire logic uart2_modem_aux_output_two,
  input wire logic fdc_irq_req,
  input wire logic fdc_dma_req,
  input wire logic pp_irq_req,
  input wire logic port_dma_request,
  input wire logic uart1_irq_req,
  input wire logic uart2_irq_req,
  input wire logic smi_req,
  input wire logic write_protect_in_n,
  // Outputs under watch
  input wire logic [15:1] irq_line,
  input wire logic [3:1] dma_line,
  input wire logic system_mgmt_irq_n,
  input wire logic fdc_write_protect_n,
  input wire logic [1:0] fdc_if_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn || !host_bus_reset_n);

  a_smi_delay: assert property ($past(resetn) && $past(host_bus_reset_n) |->
    system_mgmt_irq_n == !$past(smi_req)) else $error("smi output wrong");
  a_irq_from_req: assert property (|irq_line |->
    $past(fdc_irq_req | pp_irq_req | uart1_irq_req | uart2_irq_req)) else $error("irq no req");
  a_dma_from_req: assert property (|dma_line |->
    $past(fdc_dma_req | port_dma_request)) else $error("dma no req");
  a_fdc_gate_off: assert property ($past(!pp_irq_req && !uart1_irq_req && !uart2_irq_req &&
    (!floppy_dma_irq_gate || fdc_powered_down)) |-> irq_line == 15'h0000) else $error("fdc irq");
  a_ecp_dma_off: assert property ($past(!ecp_dma_enable &&
    !(fdc_dma_req && floppy_dma_irq_gate && !fdc_powered_down)) |-> dma_line == 3'h0)
    else $error("ecp dma");
  a_aux_two_off: assert property ($past(!fdc_irq_req && !pp_irq_req &&
    !uart1_modem_aux_output_two && !uart2_modem_aux_output_two) |-> irq_line == 15'h0000)
    else $error("aux off irq");
  a_ier_all_off: assert property ($past(!fdc_irq_req && !pp_irq_req &&
    uart1_irq_enable_reg == 4'h0 && uart2_irq_enable_reg == 4'h0) |-> irq_line == 15'h0000)
    else $error("ier off irq");
  a_wp_passes: assert property ($past(resetn) && $past(host_bus_reset_n) &&
    $past(!write_protect_in_n) |-> !fdc_write_protect_n) else $error("wp not passed");
  a_mode_kept: assert property ($past(resetn) && $past(host_bus_reset_n) &&
    $changed(fdc_if_mode) |-> $past(cfg_wr)) else $error("mode changed alone");

  c_irq_seven: cover property (irq_line[7]);
  c_dma_two: cover property (dma_line[2]);
  c_smi_low: cover property (!system_mgmt_irq_n);
endmodule

bind irdr_top irdr_top_monitor irdr_top_monitor_inst (.*);

// >>> irdr_host_model.sv
// Host interrupt and DMA controllers: latch every routed line seen high.
// Assumes active-high level requests sampled on mclk.
`timescale 1ns/1ps

module irdr_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Routed lines from the device
  input wire logic [15:1] irq_line,
  input wire logic [3:1] dma_line,
  // Record for the bench
  output logic [15:1] irq_seen,
  output logic [3:1] dma_seen
);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_seen <= '0;
      dma_seen <= '0;
    end else begin
      // Levels, not pulses: any high sample is a request
      irq_seen <= irq_seen | irq_line;
      dma_seen <= dma_seen | dma_line;
    end
  end
endmodule

// >>> irdr_top_tb.sv
// Self-checking bench for irdr_top through its config index/data port.
// Assumes irdr_top_monitor is bound and irdr_host_model sits on the lines.
`timescale 1ns/1ps

module irdr_top_tb;
  import irdr_pkg::*;
  logic mclk = 0, resetn = 0, host_bus_reset_n = 1, cfg_sel = 0, cfg_wr = 0, cfg_rd = 0;
  logic [7:0] cfg_wdata = 8'h00, cfg_rdata;
  logic floppy_dma_irq_gate = 0, fdc_powered_down = 0, pp_ecp_mode = 0, port_irq_enable = 0;
  logic service_irq_mask = 0, ecp_dma_enable = 0, smi_req = 0, density_in = 0;
  logic uart1_modem_aux_output_two = 0, uart2_modem_aux_output_two = 0;
  logic [2:0] pp_ecr_mode = 3'h0;
  logic [3:0] uart1_irq_enable_reg = 4'h0, uart2_irq_enable_reg = 4'h0;
  logic fdc_irq_req = 0, fdc_dma_req = 0, pp_irq_req = 0, port_dma_request = 0;
  logic uart1_irq_req = 0, uart2_irq_req = 0;
  logic write_protect_in_n = 1, drive_select0_n = 1, drive_select1_n = 1;
  logic [15:1] irq_line, irq_seen;
  logic [3:1] dma_line, dma_seen;
  logic system_mgmt_irq_n, fdc_write_protect_n, density_out, fdc_enhanced_mode2;
  logic fdc_nonburst_dma;
  logic [1:0] fdc_if_mode;
  int fail_count = 0, comparisons = 0, cycles = 0, i;

  always #10 mclk = ~mclk;

  irdr_top irdr_top_inst (.*);
  irdr_host_model irdr_host_model_inst (.*);

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string w);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string w);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  // Index then data; the last wait lets routed lines settle
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    cfg_sel = 0;
    cfg_wdata = idx;
    cfg_wr = 1;
    @(negedge mclk);
    cfg_sel = 1;
    cfg_wdata = d;
    @(negedge mclk);
    cfg_wr = 0;
    @(negedge mclk);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string w);
    cfg_sel = 0;
    cfg_wdata = idx;
    cfg_wr = 1;
    @(negedge mclk);
    cfg_wr = 0;
    cfg_sel = 1;
    cfg_rd = 1;
    @(negedge mclk);
    cfg_rd = 0;
    chk_reg(cfg_rdata, exp, w);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("BAD t=%0t timeout", $time);
      complete_run();
    end
  end

  initial begin
    repeat (20) @(negedge mclk);
    resetn = 1;
    @(negedge mclk);
    wr(8'h07, 8'h00);
    rdc(8'h70, 8'h06, "fdc irq reset");
    rdc(8'h74, 8'h02, "fdc dma reset");
    rdc(8'hf0, 8'h0e, "mode reset");
    chk_reg({4'h0, fdc_if_mode, fdc_nonburst_dma, fdc_enhanced_mode2}, 8'h0e, "pins");
    wr(8'h07, 8'h03);
    rdc(8'h74, 8'h04, "pp dma reset");
    wr(8'h07, 8'h05);
    rdc(8'h74, 8'h04, "uart dma reset");
    rdc(8'h55, 8'h00, "unmapped");
    // Parallel port on level 7, channel 1
    wr(8'h07, 8'h03);
    wr(8'h60, 8'h03);
    wr(8'h61, 8'h78);
    wr(8'h70, 8'h07);
    wr(8'h74, 8'h01);
    wr(8'h30, 8'h01);
    pp_irq_req = 1;
    port_irq_enable = 1;
    port_dma_request = 1;
    @(negedge mclk);
    chk_vec({irq_line, 1'b0}, 16'h0080, "pp irq");
    chk_vec({12'h0, dma_line, 1'b0}, 16'h0000, "pp no dma");
    port_irq_enable = 0;
    @(negedge mclk);
    chk_vec({irq_line, 1'b0}, 16'h0000, "pp irq off");
    pp_ecp_mode = 1;
    for (i = 0; i < 8; i++) begin
      pp_ecr_mode = 3'(i);
      @(negedge mclk);
      chk_vec({irq_line, 1'b0}, (i == 2 || i == 3 || i == 6) ? 16'h0080 : 16'h0, "mode");
    end
    service_irq_mask = 1;
    pp_ecr_mode = 3'h3;
    @(negedge mclk);
    chk_vec({irq_line, 1'b0}, 16'h0000, "masked");
    service_irq_mask = 0;
    ecp_dma_enable = 1;
    @(negedge mclk);
    chk_vec({irq_line, 1'b0} | {12'h0, dma_line, 1'b0}, 16'h0082, "ecp dma");
    chk_vec({irq_seen, 1'b0}, 16'h0080, "unused levels");
    @(negedge mclk);
    chk_vec({12'h0, dma_seen, 1'b0}, 16'h0002, "unused channels");
    for (i = 0; i < 8; i++) begin
      wr(8'h74, 8'(i));
      chk_vec({dma_line, 1'b0}, (i >= 1 && i <= 3) ? 16'h1 << i : 16'h0, "dma sel");
    end
    ecp_dma_enable = 0;
    // Management request stays idle while level 2 is in use
    for (i = 0; i < 16; i++) begin
      wr(8'h70, 8'(i));
      chk_vec({irq_line, 1'b0}, (i > 0) ? 16'h1 << i : 16'h0, "irq sel");
    end
    wr(8'h30, 8'h00);
    chk_vec({irq_line, 1'b0}, 16'h0000, "inactive");
    wr(8'h30, 8'h01);
    wr(8'h60, 8'h00);
    chk_vec({irq_line, 1'b0}, 16'h0000, "bad base");
    pp_irq_req = 0;
    port_dma_request = 0;
    // Serial port 1 on level 4
    wr(8'h07, 8'h04);
    wr(8'h60, 8'h03);
    wr(8'h61, 8'hf8);
    wr(8'h70, 8'h04);
    wr(8'h30, 8'h01);
    uart1_irq_req = 1;
    uart1_modem_aux_output_two = 1;
    @(negedge mclk);
    chk_vec({irq_line, 1'b0}, 16'h0000, "ier zero");
    uart1_irq_enable_reg = 4'h8;
    @(negedge mclk);
    chk_vec({irq_line, 1'b0}, 16'h0010, "uart irq");
    uart1_modem_aux_output_two = 0;
    @(negedge mclk);
    chk_vec({irq_line, 1'b0}, 16'h0000, "aux two");
    // Serial port 2 alone on level 4
    wr(8'h07, 8'h05);
    wr(8'h60, 8'h02);
    wr(8'h61, 8'hf8);
    wr(8'h70, 8'h04);
    wr(8'h30, 8'h01);
    uart2_irq_enable_reg = 4'h1;
    uart2_modem_aux_output_two = 1;
    uart2_irq_req = 1;
    @(negedge mclk);
    chk_vec({irq_line, 1'b0}, 16'h0010, "uart2 irq");
    uart2_irq_req = 0;
    // Floppy on level 6, channel 2
    wr(8'h07, 8'h00);
    wr(8'h60, 8'h03);
    wr(8'h61, 8'hf0);
    wr(8'h30, 8'h01);
    fdc_irq_req = 1;
    fdc_dma_req = 1;
    floppy_dma_irq_gate = 1;
    @(negedge mclk);
    chk_vec({irq_line[15:3], dma_line}, 16'h0042, "fdc on");
    floppy_dma_irq_gate = 0;
    @(negedge mclk);
    chk_vec({irq_line[15:3], dma_line}, 16'h0000, "gate off");
    floppy_dma_irq_gate = 1;
    fdc_powered_down = 1;
    @(negedge mclk);
    chk_vec({irq_line[15:3], dma_line}, 16'h0000, "power down");
    wr(8'hf0, 8'h05);
    chk_reg({4'h0, fdc_if_mode, fdc_nonburst_dma, fdc_enhanced_mode2}, 8'h05, "mode");
    wr(8'hf0, 8'h02);
    chk_reg({4'h0, fdc_if_mode, fdc_nonburst_dma, fdc_enhanced_mode2}, 8'h02, "mode");
    write_protect_in_n = 0;
    @(negedge mclk);
    chk_reg({7'h0, fdc_write_protect_n}, 8'h00, "wp in");
    write_protect_in_n = 1;
    wr(8'hf1, 8'h01);
    chk_reg({7'h0, fdc_write_protect_n}, 8'h01, "wp idle");
    drive_select0_n = 0;
    @(negedge mclk);
    chk_reg({7'h0, fdc_write_protect_n}, 8'h00, "wp forced");
    drive_select0_n = 1;
    for (i = 0; i < 8; i++) begin
      density_in = i[0];
      wr(8'hf1, {4'h0, 2'(i >> 1), 2'b00});
      chk_reg({7'h0, density_out}, (i >> 1) == 2 ? 8'h1 : (i >> 1) == 3 ? 8'h0 : 8'(i[0]), "dens");
    end
    wr(8'h70, 8'h05);
    wr(8'h02, 8'h01);
    rdc(8'h70, 8'h06, "soft irq");
    rdc(8'hf0, 8'h02, "soft kept");
    host_bus_reset_n = 0;
    @(negedge mclk);
    host_bus_reset_n = 1;
    @(negedge mclk);
    rdc(8'hf0, 8'h0e, "hard reset");
    smi_req = 1;
    @(negedge mclk);
    chk_reg({7'h0, system_mgmt_irq_n}, 8'h00, "smi");
    smi_req = 0;
    complete_run();
  end
endmodule
